/* File: logic/dfr_top.sv */
// encoder settings, fault reaction codes and reaction sequencer
//
// Summary of operation
// - config bit 0 selects whether the encoder index pulse is used
// - a 16-bit alignment holds the index to rotor magnet offset
// - encoder closed-loop commutation is allowed only with a valid alignment
// - encoder entry 0 reads back two supported further entries
// - following or slippage errors run the selected deviation reaction
// - deviation code 0 coasts, 1 slow ramp, 2 quick ramp, rest reserved
// - limit switch pass sets status warning bit 7 and starts its reaction on the same edge
// - limit code minus one takes no motion reaction
// - limit codes 1 and 2 ramp slow or quick, then switch-on-disabled
// - limit codes 5 and 6 ramp, then quick-stop-active, motor energized
// - quick-stop bit is left alone; master toggles it low then high
`timescale 1ns/10ps
`default_nettype none
`include "dfr_params.svh"
module dfr_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic od_wr,
  input wire logic od_rd,
  input wire logic [15:0] od_index,
  input wire logic [7:0] od_sub,
  input wire logic [15:0] od_wdata,
  output logic [15:0] od_rdata,
  output logic od_ack,
  output logic od_err,
  input wire logic setup_align_wr,
  input wire logic [15:0] setup_align_data,
  input wire logic closed_loop_req,
  input wire logic deviation_error,
  input wire logic limit_passed,
  input wire logic ramp_done,
  input wire logic [15:0] ctrl_word,
  input wire logic warn_clear,
  input wire logic drive_reenable,
  output logic index_enable,
  output logic closed_loop_enable,
  output logic drive_disable,
  output logic ramp_slow,
  output logic ramp_quick,
  output logic quick_stop_active,
  output logic switch_on_disabled,
  output logic status_warning
);
  dfr_pkg::dfr_code_t enc_cfg, enc_align, dev_code, lim_code;
  dfr_pkg::dfr_code_t next_enc_cfg, next_enc_align, next_dev_code;
  dfr_pkg::dfr_code_t next_lim_code, next_od_rdata, chk_code;
  dfr_pkg::dfr_state_t state, next_state;
  logic align_valid, next_align_valid, qs_low_seen, next_qs_low_seen;
  logic brake_to_qs, next_brake_to_qs;
  logic next_od_ack, next_od_err, next_index_enable, next_cl_enable;
  logic next_drive_disable, next_ramp_slow, next_ramp_quick;
  logic next_qs_active, next_sod, next_warning;
  logic chk_valid, chk_is_lim;
  logic dv_valid, dv_act, dv_coast, dv_quick;
  logic lm_valid, lm_act, lm_quick, lm_to_qs;
  logic qs_bit;

  assign qs_bit = ctrl_word[`DFR_CW_QS_BIT];
  assign chk_code = od_wdata;
  assign chk_is_lim = (od_index == `DFR_IDX_LIM);

  // write filter, shared by both reaction code entries
  dfr_react_dec u_chk (
    .code(chk_code),
    .is_limit(chk_is_lim),
    .valid(chk_valid),
    .act(),
    .coast(),
    .quick(),
    .to_qs()
  );
  dfr_react_dec u_dev (
    .code(dev_code),
    .is_limit(1'b0),
    .valid(dv_valid),
    .act(dv_act),
    .coast(dv_coast),
    .quick(dv_quick),
    .to_qs()
  );
  dfr_react_dec u_lim (
    .code(lim_code),
    .is_limit(1'b1),
    .valid(lm_valid),
    .act(lm_act),
    .coast(),
    .quick(lm_quick),
    .to_qs(lm_to_qs)
  );

  // object dictionary access and settings
  always_comb begin
    next_enc_cfg = enc_cfg;
    next_enc_align = enc_align;
    next_align_valid = align_valid;
    next_dev_code = dev_code;
    next_lim_code = lim_code;
    next_od_rdata = od_rdata;
    next_od_ack = 1'b0;
    next_od_err = 1'b0;
    if (setup_align_wr) begin
      next_enc_align = setup_align_data;
      next_align_valid = 1'b1;
    end
    if (od_wr) begin
      next_od_ack = 1'b1;
      if (od_index == `DFR_IDX_ENC && od_sub == `DFR_SUB_CFG) begin
        next_enc_cfg = od_wdata;
      end else if (od_index == `DFR_IDX_ENC && od_sub == `DFR_SUB_ALIGN) begin
        next_enc_align = od_wdata;
        next_align_valid = 1'b1;
      end else if ((od_index == `DFR_IDX_DEV || chk_is_lim) &&
                   od_sub == `DFR_SUB_COUNT) begin
        if (!chk_valid) begin
          next_od_err = 1'b1;
        end else if (chk_is_lim) begin
          next_lim_code = od_wdata;
        end else begin
          next_dev_code = od_wdata;
        end
      end else begin
        // entry count is read-only; unknown entries abort
        next_od_err = 1'b1;
      end
    end else if (od_rd) begin
      next_od_ack = 1'b1;
      next_od_rdata = 16'h0000;
      if (od_index == `DFR_IDX_ENC && od_sub == `DFR_SUB_COUNT) begin
        next_od_rdata = `DFR_ENC_SUBS;
      end else if (od_index == `DFR_IDX_ENC && od_sub == `DFR_SUB_CFG) begin
        next_od_rdata = enc_cfg;
      end else if (od_index == `DFR_IDX_ENC && od_sub == `DFR_SUB_ALIGN) begin
        next_od_rdata = enc_align;
      end else if (od_index == `DFR_IDX_DEV && od_sub == `DFR_SUB_COUNT) begin
        next_od_rdata = dev_code;
      end else if (chk_is_lim && od_sub == `DFR_SUB_COUNT) begin
        next_od_rdata = lim_code;
      end else begin
        next_od_err = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enc_cfg <= `DFR_CFG_RESET;
      enc_align <= `DFR_ALIGN_RESET;
      align_valid <= 1'b0;
      dev_code <= `DFR_REACT_RESET;
      lim_code <= `DFR_REACT_RESET;
      od_rdata <= 16'h0000;
      od_ack <= 1'b0;
      od_err <= 1'b0;
    end else begin
      enc_cfg <= next_enc_cfg;
      enc_align <= next_enc_align;
      align_valid <= next_align_valid;
      dev_code <= next_dev_code;
      lim_code <= next_lim_code;
      od_rdata <= next_od_rdata;
      od_ack <= next_od_ack;
      od_err <= next_od_err;
    end
  end

  // reaction sequencer; a limit event outranks a deviation event
  always_comb begin
    next_state = state;
    next_brake_to_qs = brake_to_qs;
    next_qs_low_seen = qs_low_seen;
    next_ramp_slow = ramp_slow;
    next_ramp_quick = ramp_quick;
    next_warning = status_warning;
    if (warn_clear) begin
      next_warning = 1'b0;
    end
    if (limit_passed) begin
      next_warning = 1'b1;
    end
    case (state)
      dfr_pkg::DFR_RUN: begin
        if (limit_passed && lm_valid && lm_act) begin
          next_state = dfr_pkg::DFR_BRAKE;
          next_brake_to_qs = lm_to_qs;
          next_ramp_quick = lm_quick;
          next_ramp_slow = !lm_quick;
        end else if (deviation_error && dv_valid && dv_act) begin
          next_brake_to_qs = 1'b0;
          if (dv_coast) begin
            next_state = dfr_pkg::DFR_SW_ON_DIS;
          end else begin
            next_state = dfr_pkg::DFR_BRAKE;
            next_ramp_quick = dv_quick;
            next_ramp_slow = !dv_quick;
          end
        end
      end
      dfr_pkg::DFR_BRAKE: begin
        if (ramp_done) begin
          next_ramp_slow = 1'b0;
          next_ramp_quick = 1'b0;
          next_qs_low_seen = 1'b0;
          next_state = brake_to_qs ? dfr_pkg::DFR_QS_ACTIVE :
                                     dfr_pkg::DFR_SW_ON_DIS;
        end
      end
      dfr_pkg::DFR_QS_ACTIVE: begin
        // control word is only read here, never forced low
        if (!qs_bit) begin
          next_qs_low_seen = 1'b1;
        end else if (qs_low_seen) begin
          next_state = dfr_pkg::DFR_RUN;
        end
      end
      default: begin
        if (drive_reenable) begin
          next_state = dfr_pkg::DFR_RUN;
        end
      end
    endcase
    next_qs_active = (next_state == dfr_pkg::DFR_QS_ACTIVE);
    next_sod = (next_state == dfr_pkg::DFR_SW_ON_DIS);
    next_drive_disable = next_sod;
    next_index_enable = next_enc_cfg[`DFR_CFG_INDEX_BIT];
    next_cl_enable = closed_loop_req && next_align_valid;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= dfr_pkg::DFR_RUN;
      brake_to_qs <= 1'b0;
      qs_low_seen <= 1'b0;
      ramp_slow <= 1'b0;
      ramp_quick <= 1'b0;
      status_warning <= 1'b0;
      quick_stop_active <= 1'b0;
      switch_on_disabled <= 1'b0;
      drive_disable <= 1'b0;
      index_enable <= 1'b0;
      closed_loop_enable <= 1'b0;
    end else begin
      state <= next_state;
      brake_to_qs <= next_brake_to_qs;
      qs_low_seen <= next_qs_low_seen;
      ramp_slow <= next_ramp_slow;
      ramp_quick <= next_ramp_quick;
      status_warning <= next_warning;
      quick_stop_active <= next_qs_active;
      switch_on_disabled <= next_sod;
      drive_disable <= next_drive_disable;
      index_enable <= next_index_enable;
      closed_loop_enable <= next_cl_enable;
    end
  end
endmodule : dfr_top
`default_nettype wire

/* File: logic/dfr_params.svh */
// constants of the drive fault reaction and encoder configuration block
`ifndef DFR_PARAMS_SVH
`define DFR_PARAMS_SVH
`define DFR_IDX_ENC 16'h33a0
`define DFR_IDX_DEV 16'h3700
`define DFR_IDX_LIM 16'h3701
`define DFR_SUB_COUNT 8'h00
`define DFR_SUB_CFG 8'h01
`define DFR_SUB_ALIGN 8'h02
`define DFR_ENC_SUBS 16'h0002
`define DFR_CFG_RESET 16'h0000
`define DFR_ALIGN_RESET 16'h0000
`define DFR_REACT_RESET 16'hffff
`define DFR_CFG_INDEX_BIT 0
`define DFR_CW_QS_BIT 2
`define DFR_SW_WARN_BIT 7
`define DFR_CODE_NONE 16'hffff
`define DFR_CODE_COAST 16'h0000
`define DFR_CODE_SLOW 16'h0001
`define DFR_CODE_QUICK 16'h0002
`define DFR_CODE_SLOW_QS 16'h0005
`define DFR_CODE_QUICK_QS 16'h0006
`endif

/* File: logic/dfr_pkg.sv */
// types of the drive fault reaction block
`default_nettype none
package dfr_pkg;
  typedef logic [15:0] dfr_code_t;
  typedef enum logic [1:0] {
    DFR_RUN = 2'b00,
    DFR_BRAKE = 2'b01,
    DFR_QS_ACTIVE = 2'b11,
    DFR_SW_ON_DIS = 2'b10
  } dfr_state_t;
endpackage : dfr_pkg
`default_nettype wire

/* File: logic/dfr_react_dec.sv */
// decoder of a reaction code into its action and follow-on state
`timescale 1ns/10ps
`default_nettype none
`include "dfr_params.svh"
module dfr_react_dec (
  input wire dfr_pkg::dfr_code_t code,
  input wire logic is_limit,
  output logic valid,
  output logic act,
  output logic coast,
  output logic quick,
  output logic to_qs
);
  always_comb begin
    valid = 1'b0;
    act = 1'b0;
    coast = 1'b0;
    quick = 1'b0;
    to_qs = 1'b0;
    if (!is_limit) begin
      if (code == `DFR_CODE_COAST) begin
        valid = 1'b1;
        act = 1'b1;
        coast = 1'b1;
      end else if (code == `DFR_CODE_SLOW) begin
        valid = 1'b1;
        act = 1'b1;
      end else if (code == `DFR_CODE_QUICK) begin
        valid = 1'b1;
        act = 1'b1;
        quick = 1'b1;
      end
    end else begin
      if (code == `DFR_CODE_NONE) begin
        valid = 1'b1;
      end else if (code == `DFR_CODE_SLOW || code == `DFR_CODE_QUICK) begin
        valid = 1'b1;
        act = 1'b1;
        quick = (code == `DFR_CODE_QUICK);
      end else if (code == `DFR_CODE_SLOW_QS ||
                   code == `DFR_CODE_QUICK_QS) begin
        valid = 1'b1;
        act = 1'b1;
        to_qs = 1'b1;
        quick = (code == `DFR_CODE_QUICK_QS);
      end
    end
  end
endmodule : dfr_react_dec
`default_nettype wire

/* File: testbench/dfr_top_assertions.sv */
// port checker of the fault reaction block
`timescale 1ns/10ps
`default_nettype none
module dfr_top_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic od_wr,
  input wire logic od_rd,
  input wire logic [15:0] od_index,
  input wire logic [7:0] od_sub,
  input wire logic [15:0] od_wdata,
  input wire logic [15:0] od_rdata,
  input wire logic od_ack,
  input wire logic od_err,
  input wire logic limit_passed,
  input wire logic ramp_done,
  input wire logic [15:0] ctrl_word,
  input wire logic drive_disable,
  input wire logic ramp_slow,
  input wire logic ramp_quick,
  input wire logic quick_stop_active,
  input wire logic switch_on_disabled,
  input wire logic status_warning
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_RD_COUNT: assert property (
    od_rd && !od_wr && od_index == 16'h33a0 && od_sub == 8'h00
    |=> od_ack && !od_err && od_rdata == 16'h0002) else $error("bad count");
  AST_DEV_REFUSE: assert property (
    od_wr && od_index == 16'h3700 && od_sub == 8'h00 && od_wdata > 16'h0002
    |=> od_ack && od_err) else $error("reserved code taken");
  AST_WARN: assert property (limit_passed |=> status_warning)
    else $error("warning not set");
  AST_ONE_RAMP: assert property (!(ramp_slow && ramp_quick))
    else $error("two ramps at once");
  AST_RAMP_HOLD: assert property (
    (ramp_slow || ramp_quick) && !ramp_done
    |=> $stable({ramp_slow, ramp_quick})) else $error("ramp dropped");
  AST_QS_ENTRY: assert property (
    $rose(quick_stop_active) |-> $past(ramp_done)
    && ($past(ramp_slow) || $past(ramp_quick))) else $error("qs w/o ramp");
  AST_QS_EXIT: assert property (
    $fell(quick_stop_active) |-> $past(ctrl_word[2]))
    else $error("qs left without bit");
  AST_SOD_COAST: assert property (
    switch_on_disabled |-> drive_disable && !ramp_slow && !ramp_quick)
    else $error("disabled state drives");
  cover property ($rose(quick_stop_active));
  cover property ($rose(switch_on_disabled));
  cover property (od_ack && od_err);
endmodule : dfr_top_assertions
`default_nettype wire

/* File: testbench/dfr_master.sv */
// fieldbus master model issuing object accesses
`timescale 1ns/10ps
`default_nettype none
module dfr_master (
  input wire logic clk,
  input wire logic od_ack,
  input wire logic od_err,
  input wire logic [15:0] od_rdata,
  output logic od_wr,
  output logic od_rd,
  output logic [15:0] od_index,
  output logic [7:0] od_sub,
  output logic [15:0] od_wdata,
  output logic [15:0] ctrl_word
);
  initial begin
    od_wr = 1'b0;
    od_rd = 1'b0;
    od_index = 16'h0000;
    od_sub = 8'h00;
    od_wdata = 16'h0000;
    ctrl_word = 16'h0004;
  end
  task automatic access(input logic wr, input logic [15:0] idx,
    input logic [7:0] sub, input logic [15:0] wd,
    output logic [15:0] rd, output logic ak, output logic er);
    @(posedge clk);
    od_wr <= wr;
    od_rd <= !wr;
    od_index <= idx;
    od_sub <= sub;
    od_wdata <= wd;
    @(posedge clk);
    od_wr <= 1'b0;
    od_rd <= 1'b0;
    // ack and err stand only in the cycle after the taking edge; read data holds until the next read
    #1;
    rd = od_rdata;
    ak = od_ack;
    er = od_err;
  endtask : access
  // low then high, the only way from quick-stop-active back to run
  task automatic qs_toggle();
    @(posedge clk);
    ctrl_word <= ctrl_word & 16'hfffb;
    @(posedge clk);
    ctrl_word <= ctrl_word | 16'h0004;
  endtask : qs_toggle
endmodule : dfr_master
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench of the fault reaction block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cl_req = 1'b0;
  logic [5:0] ev = 6'h00;
  logic [15:0] sa_data = 16'h0000;
  logic [15:0] rd, v, stored;
  logic ak, er, ie, w, cl, vl;
  logic [31:0] seed = 32'h00010d8a;
  int bad_count = 0;
  int n_compared = 0;
  logic [15:0] codes [7] = '{16'hffff, 16'h0000, 16'h0001, 16'h0002,
    16'h0005, 16'h0006, 16'h0003};
  wire logic od_wr, od_rd, od_ack, od_err;
  wire logic [7:0] st, od_sub;
  wire logic [15:0] od_index, od_wdata, od_rdata, ctrl_word;
  dfr_top dfr_top_inst (.clk(clk), .rst_n(rst_n), .od_wr(od_wr),
    .od_rd(od_rd), .od_index(od_index), .od_sub(od_sub), .od_wdata(od_wdata),
    .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err),
    .setup_align_wr(ev[5]), .setup_align_data(sa_data),
    .closed_loop_req(cl_req), .deviation_error(ev[0]), .limit_passed(ev[1]),
    .ramp_done(ev[2]), .ctrl_word(ctrl_word), .warn_clear(ev[3]),
    .drive_reenable(ev[4]), .index_enable(st[7]), .status_warning(st[6]),
    .drive_disable(st[5]), .closed_loop_enable(st[4]), .ramp_slow(st[3]),
    .ramp_quick(st[2]), .quick_stop_active(st[1]),
    .switch_on_disabled(st[0]));
  dfr_master dfr_master_inst (.clk(clk), .od_ack(od_ack), .od_err(od_err),
    .od_rdata(od_rdata), .od_wr(od_wr), .od_rd(od_rd), .od_index(od_index),
    .od_sub(od_sub), .od_wdata(od_wdata), .ctrl_word(ctrl_word));
  initial begin
    forever #20 clk = ~clk;
  end
  function automatic logic [15:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : xs
  function automatic logic code_ok(input logic lim, input logic [15:0] c);
    return lim ? (c inside {16'hffff, 16'h0001, 16'h0002, 16'h0005,
      16'h0006}) : (c <= 16'h0002);
  endfunction : code_ok
  // {slow, quick, then quick-stop-active, immediate coast}
  function automatic logic [3:0] exp_react(input logic lim,
    input logic [15:0] c);
    exp_react[3] = c == 16'h0001 || (lim && c == 16'h0005);
    exp_react[2] = c == 16'h0002 || (lim && c == 16'h0006);
    exp_react[1] = lim && (c == 16'h0005 || c == 16'h0006);
    exp_react[0] = !lim && c == 16'h0000;
  endfunction : exp_react
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic pulse(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev[b] <= 1'b0;
    #1;
  endtask : pulse
  task automatic react(input logic lim, input logic [15:0] c);
    logic [3:0] e;
    logic sd;
    e = exp_react(lim, c);
    sd = e[0] || ((e[3] || e[2]) && !e[1]);
    pulse(lim ? 1 : 0);
    w = w || lim;
    chk({8'h00, st}, {8'h00, ie, w, e[0], cl, e[3:2], 1'b0, e[0]});
    if (e[3] || e[2]) begin
      repeat (xs() % 16'h0004) @(posedge clk);
      pulse(2);
      chk({8'h00, st}, {8'h00, ie, w, sd, cl, 2'b00, e[1], sd});
    end
    if (e[1]) begin
      dfr_master_inst.qs_toggle();
      @(posedge clk);
      #1;
    end else if (sd) begin
      pulse(4);
    end
    pulse(3);
    w = 1'b0;
    chk({8'h00, st}, {8'h00, ie, 2'b00, cl, 4'h0});
  endtask : react
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #3000000;
    bad_count++;
    $display("[ERR] %0t run hung", $time);
    tally_and_finish();
  end
  initial begin
    {ie, w, cl} = 3'b000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    cl_req <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      dfr_master_inst.access(1'b0, 16'h33a0, 8'(s), 16'h0000, rd, ak, er);
      chk(rd, s == 0 ? 16'h0002 : 16'h0000);
    end
    for (int k = 0; k < 4; k++) begin
      v = xs();
      v[0] = k[0];
      ie = v[0];
      dfr_master_inst.access(1'b1, 16'h33a0, 8'h01, v, rd, ak, er);
      dfr_master_inst.access(1'b0, 16'h33a0, 8'h01, v, rd, ak, er);
      chk(rd, v);
      chk({8'h00, st}, {8'h00, ie, 7'h00});
    end
    // read-only count entry and an unmapped index both refuse
    for (int j = 0; j < 2; j++) begin
      dfr_master_inst.access(1'b1, j ? 16'h3702 : 16'h33a0, 8'h00, v, rd,
        ak, er);
      chk({14'h0000, ak, er}, 16'h0003);
    end
    $display("encoder settings done");
    v = xs();
    sa_data <= v;
    pulse(5);
    @(posedge clk);
    #1;
    cl = 1'b1;
    chk({8'h00, st}, {8'h00, ie, 2'b00, cl, 4'h0});
    dfr_master_inst.access(1'b0, 16'h33a0, 8'h02, v, rd, ak, er);
    chk(rd, v);
    v = xs();
    dfr_master_inst.access(1'b1, 16'h33a0, 8'h02, v, rd, ak, er);
    dfr_master_inst.access(1'b0, 16'h33a0, 8'h02, v, rd, ak, er);
    chk(rd, v);
    // limit pass and clear in one cycle: the set wins
    @(posedge clk);
    ev[3:1] <= 3'b101;
    @(posedge clk);
    ev[3:1] <= 3'b000;
    #1;
    chk({15'h0000, st[6]}, 16'h0001);
    w = 1'b1;
    $display("alignment done");
    for (int lim = 0; lim < 2; lim++) begin
      stored = 16'hffff;
      for (int i = 0; i < 7; i++) begin
        dfr_master_inst.access(1'b1, lim ? 16'h3701 : 16'h3700, 8'h00,
          codes[i], rd, ak, er);
        vl = code_ok(lim[0], codes[i]);
        if (vl) stored = codes[i];
        chk({14'h0000, ak, er}, {14'h0000, 1'b1, !vl});
        dfr_master_inst.access(1'b0, lim ? 16'h3701 : 16'h3700, 8'h00,
          codes[i], rd, ak, er);
        chk(rd, stored);
        react(lim[0], stored);
      end
      $display("reaction set %0d done", lim);
    end
    tally_and_finish();
  end
endmodule : tb
bind dfr_top dfr_top_assertions dfr_top_assertions_inst (.clk(clk),
  .rst_n(rst_n), .od_wr(od_wr), .od_rd(od_rd), .od_index(od_index),
  .od_sub(od_sub), .od_wdata(od_wdata), .od_rdata(od_rdata),
  .od_ack(od_ack), .od_err(od_err), .limit_passed(limit_passed),
  .ramp_done(ramp_done), .ctrl_word(ctrl_word),
  .drive_disable(drive_disable), .ramp_slow(ramp_slow),
  .ramp_quick(ramp_quick), .quick_stop_active(quick_stop_active),
  .switch_on_disabled(switch_on_disabled), .status_warning(status_warning));
`default_nettype wire
